// *** hdl/pdc_core.sv ***
// divider and control core of the integer-n synthesizer
`timescale 1ns/1ps
module pdc_core
  import pdc_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     rstn,
  input  wire logic     ser_clk,
  input  wire logic     ser_data,
  input  wire logic     latch_strobe,
  input  wire logic     chip_en,
  input  wire logic     osc_in,
  input  wire logic     pre_in,
  output pdc_pin_t      pump_output,
  output logic          modulus_hi,
  output logic          loop_sleep
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [SHIFT_W-1:0]   shift_w;

  logic [SYNC_W-1:0]    meta_q;
  logic [SYNC_W-1:0]    sync_q;
  logic [SYNC_W-1:0]    last_q;
  logic [SYNC_W-1:0]    meta_d;
  logic [SYNC_W-1:0]    sync_d;
  logic [SYNC_W-1:0]    last_d;
  logic [SYNC_W-1:0]    rise_w;

  logic                 strobe_rise;
  logic                 ce_s;

  pdc_ref_t             ref_q;
  pdc_ref_t             ref_d;
  pdc_fb_t              fb_q;
  pdc_fb_t              fb_d;

  logic                 asleep_q;
  logic                 asleep_d;
  logic                 hold_w;

  logic [RATIO_W-1:0]   ref_cnt;
  logic                 ref_pulse;
  logic [RATIO_W-1:0]   fb_cnt;
  logic                 fb_pulse;

  logic                 up_q;
  logic                 up_d;
  logic                 down_q;
  logic                 down_d;

  pdc_pin_t             pump_q;
  pdc_pin_t             pump_d;
  logic                 mod_q;
  logic                 mod_d;

  logic                 raise_w;
  logic                 lower_w;

  ////////////////////////////////////////////////////////////////////////
  // serial port, runs on the host clock and never stops for sleep

  pdc_ser_shift u_shift (
    .ser_clk  (ser_clk),
    .rstn     (rstn),
    .ser_data (ser_data),
    .shift_o  (shift_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the strobe, enable and both divider input pins, plus a third stage for edges
  // the first stage feeds only the second; edges look at stages two and three

  always_comb begin
    meta_d = '0;
    meta_d[PIN_LATCH] = latch_strobe;
    meta_d[PIN_CE]    = chip_en;
    meta_d[PIN_OSC]   = osc_in;
    meta_d[PIN_PRE]   = pre_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign rise_w      = sync_q & ~last_q;
  assign strobe_rise = rise_w[PIN_LATCH];
  assign ce_s        = sync_q[PIN_CE];

  ////////////////////////////////////////////////////////////////////////
  // latches: the shift word is read only at the synchronised strobe edge,
  // when the host has stopped its serial clock, so the word is quiet

  always_comb begin
    ref_d = ref_q;
    fb_d  = fb_q;
    if (strobe_rise) begin
      if (shift_w[ADDR_POS]) begin
        ref_d = pdc_ref_t'(shift_w[DATA_LSB +: REF_W]);
      end else begin
        fb_d = pdc_fb_t'(shift_w[DATA_LSB +: FB_W]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= pdc_ref_t'(REF_RST);
      fb_q  <= pdc_fb_t'(FB_RST);
    end else begin
      ref_q <= ref_d;
      fb_q  <= fb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power modes; the synchronous one waits for the pump to go quiet

  always_comb begin
    if (!ce_s || (fb_q.counter_clear && fb_q.sleep_bit)) begin
      asleep_d = 1'b1;
    end else if (!fb_q.counter_clear && fb_q.sleep_bit) begin
      asleep_d = asleep_q | ~(up_q | down_q);
    end else begin
      asleep_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      asleep_q <= 1'b1;
    end else begin
      asleep_q <= asleep_d;
    end
  end

  // both counters released in the same cycle, so they restart aligned
  assign hold_w = asleep_q | (fb_q.counter_clear & ~fb_q.sleep_bit);

  ////////////////////////////////////////////////////////////////////////
  // reference and feedback counters

  pdc_div_cnt #(
    .W (RATIO_W)
  ) u_ref_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .tick    (rise_w[PIN_OSC]),
    .hold    (hold_w),
    .ratio   (ref_q.ref_divide_value),
    .count_o (ref_cnt),
    .pulse_o (ref_pulse)
  );

  // counts prescaler cycles; one wrap is B cycles of PRESC_P or PRESC_P+1
  pdc_div_cnt #(
    .W (RATIO_W)
  ) u_fb_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .tick    (rise_w[PIN_PRE]),
    .hold    (hold_w),
    .ratio   (fb_q.main_count),
    .count_o (fb_cnt),
    .pulse_o (fb_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // phase detector: a pulse from each side sets a flag, both together clear

  always_comb begin
    up_d   = up_q | ref_pulse;
    down_d = down_q | fb_pulse;
    if ((up_d && down_d) || asleep_q) begin
      up_d   = 1'b0;
      down_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_q   <= 1'b0;
      down_q <= 1'b0;
    end else begin
      up_q   <= up_d;
      down_q <= down_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pump pin and modulus select; test mode drives the pin even with the float bit set

  assign raise_w = ref_q.detector_polarity ? up_q : down_q;
  assign lower_w = ref_q.detector_polarity ? down_q : up_q;

  always_comb begin
    pump_d.drv  = 1'b0;
    pump_d.oe_n = 1'b1;
    if (asleep_q) begin
      pump_d.oe_n = 1'b1;
    end else if (ref_q.test_mode) begin
      pump_d.oe_n = 1'b0;
      pump_d.drv  = ref_q.detector_polarity ? fb_pulse : ref_pulse;
    end else if (ref_q.pump_float_bit) begin
      pump_d.oe_n = 1'b1;
    end else if (raise_w) begin
      pump_d.oe_n = 1'b0;
      pump_d.drv  = 1'b1;
    end else if (lower_w) begin
      pump_d.oe_n = 1'b0;
      pump_d.drv  = 1'b0;
    end
    // swallow phase: first A prescaler cycles of each wrap ask for P+1
    mod_d = ~hold_w && (fb_cnt < RATIO_W'(fb_q.swallow_count));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pump_q <= '{drv: 1'b0, oe_n: 1'b1};
      mod_q  <= 1'b0;
    end else begin
      pump_q <= pump_d;
      mod_q  <= mod_d;
    end
  end

  assign pump_output = pump_q;
  assign modulus_hi  = mod_q;
  assign loop_sleep  = asleep_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_float_pump: assert property (
    (!ref_q.test_mode && ref_q.pump_float_bit) |=> pump_q.oe_n)
    else $error("pump driven while float bit set");

  chk_polarity_up: assert property (
    (!asleep_q && !ref_q.test_mode && !ref_q.pump_float_bit && up_q && !down_q)
    |=> (!pump_q.oe_n && pump_q.drv == $past(ref_q.detector_polarity)))
    else $error("pump direction does not follow polarity");

  chk_test_route: assert property (
    (!asleep_q && ref_q.test_mode)
    |=> (!pump_q.oe_n && pump_q.drv ==
         ($past(ref_q.detector_polarity) ? $past(fb_pulse) : $past(ref_pulse))))
    else $error("test mode routed the wrong divider");

  chk_fb_latch: assert property (
    (strobe_rise && !shift_w[ADDR_POS]) |=> fb_q == $past(shift_w[DATA_LSB +: FB_W]))
    else $error("feedback word not latched");

  chk_ref_latch: assert property (
    (strobe_rise && shift_w[ADDR_POS]) |=> ref_q == $past(shift_w[DATA_LSB +: REF_W]))
    else $error("reference word not latched");

  chk_settings_stable: assert property (
    !strobe_rise |=> ($stable(ref_q) && $stable(fb_q)))
    else $error("settings changed without a strobe edge");

  chk_swallow_mod: assert property (
    (!hold_w && fb_cnt < RATIO_W'(fb_q.swallow_count)) |=> mod_q)
    else $error("modulus high missing in swallow phase");

  chk_async_down: assert property (
    (!ce_s || (fb_q.counter_clear && fb_q.sleep_bit)) |=> (asleep_q ##1 pump_q.oe_n))
    else $error("asynchronous power-down late");

  chk_sync_wait: assert property (
    (ce_s && !fb_q.counter_clear && fb_q.sleep_bit && !asleep_q && (up_q || down_q))
    |=> !asleep_q)
    else $error("synchronous power-down cut a pump pulse");

  chk_clear_hold: assert property (
    hold_w |=> (ref_cnt == '0 && fb_cnt == '0))
    else $error("counters not held at zero");

  // a sleeping loop must show no pump drive, no pending flags and the low modulus
  chk_sleep_quiet: assert property (
    asleep_q |=> (pump_q.oe_n && !up_q && !down_q && !mod_q))
    else $error("sleeping loop not quiet");

  chk_mod_low: assert property (
    (!hold_w && fb_cnt >= RATIO_W'(fb_q.swallow_count)) |=> !mod_q)
    else $error("modulus high outside swallow phase");

  cov_ref_latch:  cover property (strobe_rise && shift_w[ADDR_POS]);
  cov_sync_sleep: cover property (fb_q.sleep_bit && !fb_q.counter_clear && $rose(asleep_q));
  cov_test_out:   cover property (ref_q.test_mode && pump_q.drv);
  cov_fb_wrap:    cover property (fb_pulse && fb_q.swallow_count != '0);
  cov_float_hold: cover property (!asleep_q && ref_q.pump_float_bit && !ref_q.test_mode && up_q);

endmodule

// *** hdl/pdc_pkg.sv ***
// constants, field layouts and carrier types of the synthesizer divider control
//
// Summary of operation
// - reference oscillator divided by ratio 2..1023
// - pump float bit tri-states pump outside test mode, detector keeps running
// - polarity bit swaps pump up and down
// - test mode routes a divider to pump pin
// - polarity picks reference or feedback divider in test
// - strobe with address 0 loads feedback word
// - feedback word: main, swallow, control pair
// - modulus P+1 for A cycles, P after
// - sync power-down waits for pump pulse end
// - both bits or enable low: sleep at once
// - counter clear resets both counters and holds modulus low
// - asleep counters held at zero, restart aligned
// - serial port works in every sleep mode
// - serial data MSB first, rising clock edge
// - strobe with address 1 loads reference word
package pdc_pkg;

  localparam int SHIFT_W   = 18;
  localparam int REF_W     = 14;
  localparam int FB_W      = 17;
  localparam int RATIO_W   = 10;
  localparam int SWALLOW_W = 5;
  localparam int SYNC_W    = 4;

  // shift register layout
  localparam int ADDR_POS  = 0;
  localparam int DATA_LSB  = 1;

  // prescaler modulus, low setting
  localparam int PRESC_P   = 32;

  // pin slots in the synchroniser vector
  localparam int PIN_LATCH = 0;
  localparam int PIN_CE    = 1;
  localparam int PIN_OSC   = 2;
  localparam int PIN_PRE   = 3;

  // values after reset: pump floating, loop asleep until programmed
  localparam logic [REF_W-1:0]   REF_RST   = 14'h0402;
  localparam logic [FB_W-1:0]    FB_RST    = 17'h00183;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 18'h00000;

  typedef struct packed {
    logic                  test_mode;
    logic                  spare_bit;
    logic                  detector_polarity;
    logic                  pump_float_bit;
    logic [RATIO_W-1:0]    ref_divide_value;
  } pdc_ref_t;

  typedef struct packed {
    logic [RATIO_W-1:0]    main_count;
    logic [SWALLOW_W-1:0]  swallow_count;
    logic                  counter_clear;
    logic                  sleep_bit;
  } pdc_fb_t;

  typedef struct packed {
    logic drv;
    logic oe_n;
  } pdc_pin_t;

endpackage

// *** hdl/pdc_ser_shift.sv ***
// serial shift register on the host serial clock
`timescale 1ns/1ps
module pdc_ser_shift
  import pdc_pkg::*;
(
  input  wire logic               ser_clk,
  input  wire logic               rstn,
  input  wire logic               ser_data,
  output logic [SHIFT_W-1:0]      shift_o
);

  logic [SHIFT_W-1:0] sr_q;
  logic [SHIFT_W-1:0] sr_d;

  ////////////////////////////////////////////////////////////////////////
  // shift toward the msb, new bit enters at the address end
  always_comb begin
    sr_d = {sr_q[SHIFT_W-2:0], ser_data};
  end

  always_ff @(posedge ser_clk or negedge rstn) begin
    if (!rstn) begin
      sr_q <= SHIFT_RST;
    end else begin
      sr_q <= sr_d;
    end
  end

  assign shift_o = sr_q;

  ////////////////////////////////////////////////////////////////////////
  chk_shift_order: assert property (@(posedge ser_clk) disable iff (!rstn)
    1'b1 |=> (sr_q[0] == $past(ser_data)) && (sr_q[SHIFT_W-1:1] == $past(sr_q[SHIFT_W-2:0])))
    else $error("serial bit not shifted in msb first");

endmodule

// *** hdl/pdc_div_cnt.sv ***
// programmable counter, shared by the reference and feedback dividers
`timescale 1ns/1ps
module pdc_div_cnt #(
  parameter int W = 10
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          tick,
  input  wire logic          hold,
  input  wire logic [W-1:0]  ratio,
  output logic [W-1:0]       count_o,
  output logic               pulse_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         pls_q;
  logic         pls_d;

  ////////////////////////////////////////////////////////////////////////
  // >= rather than == so a smaller ratio loaded mid-cycle wraps at once
  always_comb begin
    cnt_d = cnt_q;
    pls_d = 1'b0;
    if (hold) begin
      cnt_d = '0;
    end else if (tick) begin
      if (cnt_q >= ratio - W'(1)) begin
        cnt_d = '0;
        pls_d = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      pls_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pls_q <= pls_d;
    end
  end

  assign count_o = cnt_q;
  assign pulse_o = pls_q;

  ////////////////////////////////////////////////////////////////////////
  chk_div_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!hold && tick && cnt_q >= ratio - W'(1)) |=> (pls_q && cnt_q == '0))
    else $error("divider did not wrap at its ratio");

  chk_div_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    hold |=> (cnt_q == '0) && !pls_q)
    else $error("held divider left its load point");

endmodule

// *** test/pdc_host_model.sv ***
// host-side model of the three-wire serial port
`timescale 1ns/1ps
module pdc_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  // serial clock stands still low outside words
  initial begin
    ser_clk      = 1'b0;
    ser_data     = 1'b0;
    latch_strobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift one whole word msb first, then raise the strobe only if asked
  task automatic send(input logic [17:0] w, input bit stb);
    for (int i = 17; i >= 0; i--) begin
      ser_data = w[i];
      #24 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    // released data line must not keep a stale level
    ser_data = ~ser_data;
    if (stb) begin
      #80 latch_strobe = 1'b1;
      #200 latch_strobe = 1'b0;
    end
    #200;
  endtask
endmodule

// *** test/pdc_core_tb.sv ***
// self-checking bench of the divider control core
`timescale 1ns/1ps
module pdc_core_tb;
  import pdc_pkg::*;
  logic     sys_clk      = 1'b0;
  logic     rstn         = 1'b0;
  logic     chip_en      = 1'b1;
  logic     osc_in       = 1'b0;
  logic     pre_in       = 1'b0;
  logic     ser_clk;
  logic     ser_data;
  logic     latch_strobe;
  pdc_pin_t pump_output;
  logic     modulus_hi;
  logic     loop_sleep;
  int       failures     = 0;
  int       checks_done  = 0;
  int       pulse_cnt    = 0;
  int       mod_cnt      = 0;
  int       rdiv_v;
  int       b_v;
  int       a_v;

  always #20 sys_clk = ~sys_clk;

  pdc_host_model u_pdc_host_model (
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .latch_strobe (latch_strobe)
  );

  pdc_core u_pdc_core (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .latch_strobe (latch_strobe),
    .chip_en      (chip_en),
    .osc_in       (osc_in),
    .pre_in       (pre_in),
    .pump_output  (pump_output),
    .modulus_hi   (modulus_hi),
    .loop_sleep   (loop_sleep)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // test-mode pulses are one cycle wide, so driven high cycles count pulses
  always @(posedge sys_clk)
    if (pump_output.oe_n === 1'b0 && pump_output.drv === 1'b1)
      pulse_cnt <= pulse_cnt + 1;

  // reference word; ignored top bits and spare bit always zero
  function automatic logic [17:0] ref_w(logic t, logic p, logic f, int rd);
    return {3'b000, t, 1'b0, p, f, rd[9:0], 1'b1};
  endfunction

  // feedback word: main, swallow, control pair, address 0
  function automatic logic [17:0] fb_w(int b, int a, logic [1:0] c);
    return {b[9:0], a[4:0], c, 1'b0};
  endfunction

  // polarity 0 shows the reference divider, 1 the feedback divider
  function automatic int exp_pulses(int p);
    return (p == 1) ? rdiv_v : b_v;
  endfunction

  task automatic check_bit(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_num(string what, int exp, int got);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // offset keeps the serial traffic out of phase with the core clock
  task automatic put(logic [17:0] w, bit stb);
    #7;
    u_pdc_host_model.send(w, stb);
    @(posedge sys_clk);
  endtask

  // clear both counters first so they restart together from zero
  task automatic prog(logic [17:0] rw, logic [1:0] ctl);
    put(rw, 1'b1);
    put(fb_w(b_v, a_v, 2'b10), 1'b1);
    put(fb_w(b_v, a_v, ctl), 1'b1);
  endtask

  // three cycles per phase keeps ticks well inside the synchroniser limit
  task automatic tick(int reps, bit use_osc, bit use_pre);
    repeat (reps) begin
      mod_cnt += (modulus_hi === 1'b1);
      osc_in <= use_osc;
      pre_in <= use_pre;
      repeat (3) @(posedge sys_clk);
      osc_in <= 1'b0;
      pre_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs only a few thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    summarize();
  end

  initial begin
    rdiv_v = $urandom(32'hb60c);
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check_bit("loop_sleep", 1'b1, loop_sleep);
    check_bit("pump_oe_n", 1'b1, pump_output.oe_n);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      rdiv_v = 2 + $urandom % 8;
      b_v = 3 + $urandom % 7;
      a_v = $urandom % (b_v + 1);
      // corner: smallest ratios with swallow equal to main
      if (p == 1) begin
        rdiv_v = 2;
        b_v = 3;
        a_v = 3;
      end
      prog(ref_w(1'b1, p[0], 1'b1, rdiv_v), 2'b00);
      pulse_cnt = 0;
      mod_cnt = 0;
      tick(rdiv_v * b_v, 1'b1, 1'b1);
      check_num("pump_pulses", exp_pulses(p), pulse_cnt);
      check_num("modulus_hi_ticks", rdiv_v * a_v, mod_cnt);
      // normal mode: a lone reference pulse leaves the up command standing
      prog(ref_w(1'b0, p[0], 1'b0, rdiv_v), 2'b00);
      tick(rdiv_v, 1'b1, 1'b0);
      check_bit("pump_oe_n", 1'b0, pump_output.oe_n);
      check_bit("pump_drv", p[0], pump_output.drv);
      put(fb_w(b_v, a_v, 2'b01), 1'b1);
      check_bit("loop_sleep", 1'b0, loop_sleep);
      tick(b_v, 1'b0, 1'b1);
      check_bit("loop_sleep", 1'b1, loop_sleep);
      check_bit("pump_oe_n", 1'b1, pump_output.oe_n);
      $display("test polarity %0d done", p);
    end
    // counter clear: loop awake but no divider output
    prog(ref_w(1'b1, 1'b1, 1'b1, rdiv_v), 2'b10);
    pulse_cnt = 0;
    tick(rdiv_v * b_v, 1'b1, 1'b1);
    check_num("pump_pulses", 0, pulse_cnt);
    check_bit("loop_sleep", 1'b0, loop_sleep);
    $display("test counter clear done");
    // immediate sleep with an up command pending
    prog(ref_w(1'b0, 1'b1, 1'b0, rdiv_v), 2'b00);
    tick(rdiv_v, 1'b1, 1'b0);
    // float bit while awake: the pending up command must not reach the pin
    put(ref_w(1'b0, 1'b1, 1'b1, rdiv_v), 1'b1);
    check_bit("pump_oe_n", 1'b1, pump_output.oe_n);
    put(fb_w(b_v, a_v, 2'b11), 1'b1);
    check_bit("loop_sleep", 1'b1, loop_sleep);
    put(fb_w(b_v, a_v, 2'b00), 1'b0);
    check_bit("loop_sleep", 1'b1, loop_sleep);
    put(fb_w(b_v, a_v, 2'b00), 1'b1);
    check_bit("loop_sleep", 1'b0, loop_sleep);
    chip_en <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check_bit("loop_sleep", 1'b1, loop_sleep);
    chip_en <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check_bit("loop_sleep", 1'b0, loop_sleep);
    $display("test power control done");
    summarize();
  end
endmodule
